// ===== verilog/core_timing_pkg.sv
// Package with opcode classes, byte counts and cycle counts for the instruction timing block.
package core_timing_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int OPCODE_W = 8;
    localparam int COUNT_W = 2;
    localparam logic [1:0] COUNT_RESET = 2'h0;

    // ------------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        CLS_ONE_ONE = 5'h00,      // one byte, one cycle
        CLS_TWO_TWO = 5'h01,      // two bytes, two cycles
        CLS_ONE_TWO = 5'h02,      // one byte, two cycles
        CLS_THREE_THREE = 5'h03,  // three bytes, three cycles
        CLS_ONE_THREE = 5'h04,    // one byte, three cycles
        CLS_UNLISTED = 5'h05      // outside the decoded set
    } timing_class_t;

    // ------------------------------------------------------------------
    // Memory space targets
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPACE_NONE = 2'h0,
        SPACE_CODE_READ = 2'h1,
        SPACE_XDATA_READ = 2'h2,
        SPACE_PROGRAM_WRITE = 2'h3
    } space_t;

    // ------------------------------------------------------------------
    // Opcodes (binary compatible with the classic set)
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_CODE_READ_DP = 8'h93;
    localparam logic [7:0] OP_CODE_READ_PC = 8'h83;
    localparam logic [7:0] OP_XREAD_DP = 8'hE0;
    localparam logic [7:0] OP_XWRITE_DP = 8'hF0;
    localparam logic [7:0] OP_LOAD_DP = 8'h90;
    localparam logic [7:0] OP_DIRECT_COPY = 8'h85;
    localparam logic [7:0] OP_PUSH = 8'hC0;
    localparam logic [7:0] OP_POP = 8'hD0;
    localparam logic [7:0] OP_EXCHANGE_DIRECT = 8'hC5;
    localparam logic [7:0] OP_CLR_A = 8'hE4;
    localparam logic [7:0] OP_CPL_A = 8'hF4;
    localparam logic [7:0] OP_RR_A = 8'h03;
    localparam logic [7:0] OP_RRC_A = 8'h13;
    localparam logic [7:0] OP_RL_A = 8'h23;
    localparam logic [7:0] OP_RLC_A = 8'h33;
    localparam logic [7:0] OP_SWAP_A = 8'hC4;
    localparam logic [3:0] HI_ADD = 4'h2;
    localparam logic [3:0] HI_ADD_CARRY = 4'h3;
    localparam logic [3:0] HI_OR = 4'h4;
    localparam logic [3:0] HI_AND = 4'h5;
    localparam logic [3:0] HI_XOR = 4'h6;
    localparam logic [3:0] HI_SUB_BORROW = 4'h9;
    localparam logic [3:0] HI_EXCHANGE = 4'hC;
    localparam logic [3:0] HI_XREAD_PTR = 4'hE;
    localparam logic [3:0] HI_XWRITE_PTR = 4'hF;
    localparam logic [3:0] HI_MOV_PTR_A = 4'hF;
    localparam logic [3:0] HI_MOV_REG_IMM = 4'h7;
    localparam logic [3:0] HI_MOV_REG_DIR = 4'hA;
    localparam logic [3:0] HI_MOV_DIR_PTR = 4'h8;

endpackage : core_timing_pkg

// ===== verilog/core_decode_if.sv
// Interface carrying decoded instruction attributes from the decoder to the timing core.
`timescale 1ns/1ps
interface core_decode_if;
    logic [7:0] opcode;
    logic [1:0] length;
    logic [1:0] cycles;
    logic known;
    core_timing_pkg::space_t space;

    modport decoder (input opcode, output length, output cycles, output known, output space);
    modport core (output opcode, input length, input cycles, input known, input space);
endinterface : core_decode_if

// ===== verilog/core_opcode_decoder.sv
// Combinational opcode decoder giving byte length, cycle count and memory space.
`timescale 1ns/1ps
module core_opcode_decoder (
    core_decode_if.decoder dec // decoded attribute bundle
);

    // ------------------------------------------------------------------
    // Class lookup
    // ------------------------------------------------------------------
    function automatic core_timing_pkg::timing_class_t classify(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        logic is_reg;
        logic is_ind;
        logic is_arith;
        logic is_logic;
        hi = op[7:4];
        lo = op[3:0];
        is_reg = lo[3];
        is_ind = (lo == 4'h6) || (lo == 4'h7);
        is_arith = hi == core_timing_pkg::HI_ADD || hi == core_timing_pkg::HI_ADD_CARRY ||
                   hi == core_timing_pkg::HI_SUB_BORROW;
        is_logic = hi == core_timing_pkg::HI_OR || hi == core_timing_pkg::HI_AND || hi == core_timing_pkg::HI_XOR;
        classify = core_timing_pkg::CLS_UNLISTED;
        if (is_arith || is_logic) begin
            if (is_reg) classify = core_timing_pkg::CLS_ONE_ONE;
            else if (lo == 4'h4 || lo == 4'h5) classify = core_timing_pkg::CLS_TWO_TWO;
            else if (is_ind) classify = core_timing_pkg::CLS_ONE_TWO;
            else if (lo == 4'h2 && is_logic) classify = core_timing_pkg::CLS_TWO_TWO;
            else if (lo == 4'h3 && is_logic) classify = core_timing_pkg::CLS_THREE_THREE;
        end
        if (hi == core_timing_pkg::HI_EXCHANGE && is_reg) classify = core_timing_pkg::CLS_ONE_ONE;
        if (hi == core_timing_pkg::HI_MOV_PTR_A && is_ind) classify = core_timing_pkg::CLS_ONE_TWO;
        if ((hi == core_timing_pkg::HI_MOV_REG_IMM || hi == core_timing_pkg::HI_MOV_REG_DIR) && is_reg)
            classify = core_timing_pkg::CLS_TWO_TWO;
        if (hi == core_timing_pkg::HI_MOV_DIR_PTR && is_ind) classify = core_timing_pkg::CLS_TWO_TWO;
        if ((hi == core_timing_pkg::HI_XREAD_PTR || hi == core_timing_pkg::HI_XWRITE_PTR) &&
            (lo == 4'h2 || lo == 4'h3)) classify = core_timing_pkg::CLS_ONE_THREE;
        case (op)
            core_timing_pkg::OP_CLR_A, core_timing_pkg::OP_CPL_A, core_timing_pkg::OP_RR_A,
            core_timing_pkg::OP_RRC_A, core_timing_pkg::OP_RL_A, core_timing_pkg::OP_RLC_A,
            core_timing_pkg::OP_SWAP_A: classify = core_timing_pkg::CLS_ONE_ONE;
            core_timing_pkg::OP_PUSH, core_timing_pkg::OP_POP,
            core_timing_pkg::OP_EXCHANGE_DIRECT: classify = core_timing_pkg::CLS_TWO_TWO;
            core_timing_pkg::OP_DIRECT_COPY,
            core_timing_pkg::OP_LOAD_DP: classify = core_timing_pkg::CLS_THREE_THREE;
            core_timing_pkg::OP_CODE_READ_DP, core_timing_pkg::OP_CODE_READ_PC,
            core_timing_pkg::OP_XREAD_DP,
            core_timing_pkg::OP_XWRITE_DP: classify = core_timing_pkg::CLS_ONE_THREE;
            default: ;
        endcase
    endfunction : classify

    core_timing_pkg::timing_class_t cls;

    always_comb begin
        cls = classify(dec.opcode);
        dec.known = 1'b1;
        case (cls)
            core_timing_pkg::CLS_ONE_ONE: begin
                dec.length = 2'h1;
                dec.cycles = 2'h1;
            end
            core_timing_pkg::CLS_TWO_TWO: begin
                dec.length = 2'h2;
                dec.cycles = 2'h2;
            end
            core_timing_pkg::CLS_ONE_TWO: begin
                dec.length = 2'h1;
                dec.cycles = 2'h2;
            end
            core_timing_pkg::CLS_THREE_THREE: begin
                dec.length = 2'h3;
                dec.cycles = 2'h3;
            end
            core_timing_pkg::CLS_ONE_THREE: begin
                dec.length = 2'h1;
                dec.cycles = 2'h3;
            end
            default: begin
                dec.length = 2'h1;
                dec.cycles = 2'h1;
                dec.known = 1'b0;
            end
        endcase
    end

    // Writes of the external-data move land in program memory; there is no off-chip space.
    always_comb begin
        dec.space = core_timing_pkg::SPACE_NONE;
        if (dec.opcode == core_timing_pkg::OP_CODE_READ_DP || dec.opcode == core_timing_pkg::OP_CODE_READ_PC)
            dec.space = core_timing_pkg::SPACE_CODE_READ;
        else if (dec.opcode == core_timing_pkg::OP_XREAD_DP || dec.opcode == 8'hE2 || dec.opcode == 8'hE3)
            dec.space = core_timing_pkg::SPACE_XDATA_READ;
        else if (dec.opcode == core_timing_pkg::OP_XWRITE_DP || dec.opcode == 8'hF2 || dec.opcode == 8'hF3)
            dec.space = core_timing_pkg::SPACE_PROGRAM_WRITE;
    end

endmodule : core_opcode_decoder

// ===== verilog/core_instruction_timing.sv
// Top of the instruction timing block: fetches opcodes, sequences byte fetch and execute cycles.
`timescale 1ns/1ps
module core_instruction_timing (
    input wire logic core_clk_i,          // system clock, 40 MHz
    input wire logic rst_n_i,             // asynchronous reset, active low
    input wire logic [7:0] code_byte_i,   // program byte at fetch_addr_o
    input wire logic code_valid_i,        // program byte present this cycle
    output logic [15:0] fetch_addr_o,     // program fetch address
    output logic start_o,                 // pulse: first cycle of an instruction
    output logic done_o,                  // pulse: last cycle of an instruction
    output logic [7:0] opcode_o,          // opcode in execution
    output logic [7:0] operand1_o,        // second instruction byte
    output logic [7:0] operand2_o,        // third instruction byte
    output logic [1:0] length_o,          // byte length of current instruction
    output logic [1:0] cycles_o,          // cycle count of current instruction
    output logic unlisted_o,              // opcode is outside the timed set
    output logic code_read_o,             // pulse: code byte read issued
    output logic xdata_read_o,            // pulse: external data read issued
    output logic program_write_o          // pulse: program memory write issued
);

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b010,
        ST_LAST = 3'b100
    } seq_state_t;

    seq_state_t state_q;
    logic [1:0] bytes_q;
    logic [15:0] pc_q;
    core_decode_if dec ();

    core_opcode_decoder u_dec (
        .dec(dec.decoder)
    );

    assign dec.opcode = code_byte_i;

    // ------------------------------------------------------------------
    // Cycle sequencing
    // ------------------------------------------------------------------
    // Each instruction lasts its decoded cycle count from the opcode cycle, plus one cycle for each cycle that an owed operand byte is withheld.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_FETCH;
        end else begin
            case (state_q)
                ST_FETCH: begin
                    if (code_valid_i && dec.cycles != 2'h1) begin
                        state_q <= (dec.cycles == 2'h2) ? ST_LAST : ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (code_valid_i || bytes_q == 2'h0) begin
                        state_q <= ST_LAST;
                    end
                end
                ST_LAST: begin
                    if (code_valid_i || bytes_q == 2'h0) begin
                        state_q <= ST_FETCH;
                    end
                end
                default: state_q <= ST_FETCH;
            endcase
        end
    end

    // Bytes still to fetch after the opcode; a cycle without a byte stalls the sequencer while any remain.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bytes_q <= 2'h0;
        end else if (state_q == ST_FETCH && code_valid_i) begin
            bytes_q <= 2'(dec.length - 2'h1);
        end else if (state_q != ST_FETCH && bytes_q != 2'h0 && code_valid_i) begin
            bytes_q <= 2'(bytes_q - 2'h1);
        end
    end

    // ------------------------------------------------------------------
    // Program counter and operand capture
    // ------------------------------------------------------------------
    logic take_byte;
    assign take_byte = code_valid_i && (state_q == ST_FETCH || bytes_q != 2'h0);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q <= 16'h0000;
        end else if (take_byte) begin
            pc_q <= 16'(pc_q + 16'h0001);
        end
    end

    assign fetch_addr_o = pc_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opcode_o <= 8'h00;
            length_o <= 2'h0;
            cycles_o <= 2'h0;
            unlisted_o <= 1'b0;
        end else if (state_q == ST_FETCH && code_valid_i) begin
            opcode_o <= code_byte_i;
            length_o <= dec.length;
            cycles_o <= dec.cycles;
            unlisted_o <= ~dec.known;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operand1_o <= 8'h00;
            operand2_o <= 8'h00;
        end else if (state_q != ST_FETCH && code_valid_i && bytes_q != 2'h0) begin
            if (bytes_q == length_o - 2'h1) operand1_o <= code_byte_i;
            else operand2_o <= code_byte_i;
        end
    end

    // ------------------------------------------------------------------
    // Instruction boundary strobes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            start_o <= state_q == ST_FETCH && code_valid_i;
            done_o <= (state_q == ST_FETCH && code_valid_i && dec.cycles == 2'h1) ||
                      (state_q == ST_LAST && (code_valid_i || bytes_q == 2'h0));
        end
    end

    // ------------------------------------------------------------------
    // Memory space strobes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_read_o <= 1'b0;
            xdata_read_o <= 1'b0;
            program_write_o <= 1'b0;
        end else begin
            code_read_o <= state_q == ST_FETCH && code_valid_i &&
                           dec.space == core_timing_pkg::SPACE_CODE_READ;
            xdata_read_o <= state_q == ST_FETCH && code_valid_i &&
                            dec.space == core_timing_pkg::SPACE_XDATA_READ;
            program_write_o <= state_q == ST_FETCH && code_valid_i &&
                               dec.space == core_timing_pkg::SPACE_PROGRAM_WRITE;
        end
    end

endmodule : core_instruction_timing

// ===== test/core_timing_sva.sv
// Assertion checker for the instruction timing block.
`timescale 1ns/1ps
module core_timing_sva (
    input wire logic core_clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic [7:0] code_byte_i, // byte in
    input wire logic code_valid_i, // byte valid
    input wire logic [15:0] fetch_addr_o, // fetch address
    input wire logic start_o, // start pulse
    input wire logic done_o, // done pulse
    input wire logic [7:0] opcode_o, // opcode
    input wire logic [7:0] operand1_o, // byte two
    input wire logic [7:0] operand2_o, // byte three
    input wire logic [1:0] length_o, // length
    input wire logic [1:0] cycles_o, // cycles
    input wire logic unlisted_o, // unlisted
    input wire logic code_read_o, // code read
    input wire logic xdata_read_o, // data read
    input wire logic program_write_o // program write
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic acc_op;
    logic lgc_op;
    logic [3:0] lo;
    assign acc_op = opcode_o[7:4] inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6};
    assign lgc_op = opcode_o[7:4] inside {4'h4, 4'h5, 4'h6};
    assign lo = opcode_o[3:0];

    property shape(logic cond, logic [1:0] l, logic [1:0] c);
        start_o && cond |-> length_o == l && cycles_o == c;
    endproperty

    a_reg_single: assert property (shape(acc_op && lo[3], 2'h1, 2'h1))
        else $error("register operand shape wrong");
    a_direct_operand: assert property (shape(acc_op && lo == 4'h5, 2'h2, 2'h2))
        else $error("direct operand shape wrong");
    a_indirect_operand: assert property (shape(acc_op && lo[3:1] == 3'h3, 2'h1, 2'h2))
        else $error("indirect operand shape wrong");
    a_immediate_operand: assert property (shape(acc_op && lo == 4'h4, 2'h2, 2'h2))
        else $error("immediate operand shape wrong");
    a_logic_imm_direct: assert property (shape(lgc_op && lo == 4'h3, 2'h3, 2'h3))
        else $error("logic immediate to direct shape wrong");
    a_logic_acc_direct: assert property (shape(lgc_op && lo == 4'h2, 2'h2, 2'h2))
        else $error("logic accumulator to direct shape wrong");
    a_single_acc: assert property (
        shape(opcode_o inside {8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC4}, 2'h1, 2'h1))
        else $error("single operand shape wrong");
    a_long_move: assert property (shape(opcode_o inside {8'h85, 8'h90}, 2'h3, 2'h3))
        else $error("three byte move shape wrong");
    a_one_cycle_done: assert property (start_o && cycles_o == 2'h1 |-> done_o)
        else $error("one cycle instruction not done at once");
    a_two_cycle_done: assert property (
        start_o && cycles_o == 2'h2 && code_valid_i |-> !done_o ##1 done_o)
        else $error("two cycle instruction timing wrong");
    a_three_not_early: assert property (start_o && cycles_o == 2'h3 |-> !done_o ##1 !done_o)
        else $error("three cycle instruction ended early");
    a_three_cycle_done: assert property (
        (start_o && cycles_o == 2'h3 && code_valid_i ##1 code_valid_i) |=> done_o)
        else $error("three cycle instruction late");
    a_program_write: assert property (
        program_write_o == (start_o && opcode_o inside {8'hF0, 8'hF2, 8'hF3}))
        else $error("program write pulse wrong");
    a_xdata_read: assert property (xdata_read_o == (start_o && opcode_o inside {8'hE0, 8'hE2, 8'hE3}))
        else $error("data read pulse wrong");
    a_code_read: assert property (code_read_o == (start_o && opcode_o inside {8'h83, 8'h93}))
        else $error("code read pulse wrong");

    c_three_cycle: cover property (start_o && cycles_o == 2'h3);
    c_program_write: cover property (program_write_o);
    c_back_to_back: cover property (done_o ##1 start_o && cycles_o == 2'h1);
endmodule : core_timing_sva

bind core_instruction_timing core_timing_sva i_core_timing_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .code_byte_i(code_byte_i), .code_valid_i(code_valid_i),
    .fetch_addr_o(fetch_addr_o), .start_o(start_o), .done_o(done_o), .opcode_o(opcode_o),
    .operand1_o(operand1_o), .operand2_o(operand2_o), .length_o(length_o), .cycles_o(cycles_o),
    .unlisted_o(unlisted_o), .code_read_o(code_read_o), .xdata_read_o(xdata_read_o),
    .program_write_o(program_write_o)
);

// ===== test/tb.sv
// Self-checking testbench for the instruction timing block.
`timescale 1ns/1ps
module tb;
    logic core_clk_i;
    logic rst_n_i;
    logic [7:0] code_byte_i;
    logic code_valid_i;
    logic [15:0] fetch_addr_o;
    logic start_o;
    logic done_o;
    logic [7:0] opcode_o;
    logic [7:0] operand1_o;
    logic [7:0] operand2_o;
    logic [1:0] length_o;
    logic [1:0] cycles_o;
    logic unlisted_o;
    logic code_read_o;
    logic xdata_read_o;
    logic program_write_o;
    logic [7:0] mem [256];
    logic [15:0] pc;
    int err_count;
    int comparisons;

    // Program memory answers the fetch address in the same cycle.
    assign code_byte_i = mem[fetch_addr_o[7:0]];

    core_instruction_timing i_core_instruction_timing (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .code_byte_i(code_byte_i), .code_valid_i(code_valid_i),
        .fetch_addr_o(fetch_addr_o), .start_o(start_o), .done_o(done_o), .opcode_o(opcode_o),
        .operand1_o(operand1_o), .operand2_o(operand2_o), .length_o(length_o), .cycles_o(cycles_o),
        .unlisted_o(unlisted_o), .code_read_o(code_read_o), .xdata_read_o(xdata_read_o),
        .program_write_o(program_write_o)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Entry packs opcode, length, cycles and the flags unlisted, code read, data read, program write.
    task automatic run(input logic [15:0] e, input logic stall = 1'b0);
        int n;
        mem[pc[7:0]] = e[15:8];
        mem[pc[7:0] + 8'h01] = pc[7:0] ^ 8'h5A;
        mem[pc[7:0] + 8'h02] = ~pc[7:0];
        n = 0;
        do begin
            @(posedge core_clk_i);
            if (stall && n == 0) code_valid_i <= 1'b0;
            #1;
            n++;
        end while (start_o !== 1'b1 && n < 10);
        check("start", {15'h0000, start_o}, 16'h0001);
        check("fetch", fetch_addr_o, pc + 16'h0001);
        check("opcode", {8'h00, opcode_o}, {8'h00, e[15:8]});
        check("shape", {12'h000, length_o, cycles_o}, {12'h000, e[7:4]});
        check("flags", {12'h000, unlisted_o, code_read_o, xdata_read_o, program_write_o}, {12'h000, e[3:0]});
        n = 1;
        // A withheld byte holds the sequencer for one cycle and the fetch address with it.
        if (stall) begin
            @(posedge core_clk_i);
            code_valid_i <= 1'b1;
            #1;
            n++;
            check("stall", fetch_addr_o, pc + 16'h0001);
        end
        while (done_o !== 1'b1 && n < 8) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        check("cycles", 16'(n), {14'h0000, e[5:4]} + {15'h0000, stall});
        if (e[7:6] > 2'h1) check("operand1", {8'h00, operand1_o}, {8'h00, pc[7:0] ^ 8'h5A});
        if (e[7:6] > 2'h2) check("operand2", {8'h00, operand2_o}, {8'h00, ~pc[7:0]});
        pc = pc + {14'h0000, e[7:6]};
    endtask : run

    task automatic acc_forms(input logic [3:0] hi);
        for (int r = 8; r < 16; r++) begin
            run({hi, 4'(r), 8'h50});
        end
        run({hi, 12'h5A0});
        run({hi, 12'h660});
        run({hi, 12'h760});
        run({hi, 12'h4A0});
    endtask : acc_forms

    task automatic arith_ops();
        acc_forms(4'h2);
        acc_forms(4'h3);
        acc_forms(4'h9);
    endtask : arith_ops

    task automatic logic_ops();
        logic [3:0] hi [3] = '{4'h5, 4'h4, 4'h6};
        foreach (hi[i]) begin
            acc_forms(hi[i]);
            run({hi[i], 12'h2A0});
            run({hi[i], 12'h3F0});
        end
    endtask : logic_ops

    task automatic single_ops();
        logic [15:0] t [7] = '{16'hE450, 16'hF450, 16'h0350, 16'h1350, 16'h2350, 16'h3350, 16'hC450};
        foreach (t[i]) run(t[i]);
        run(16'hA558);
    endtask : single_ops

    task automatic transfers();
        logic [15:0] t [16] = '{16'h85F0, 16'h90F0, 16'h9374, 16'h8374, 16'hE072, 16'hE272, 16'hE372,
            16'hF071, 16'hF271, 16'hF371, 16'hC0A0, 16'hD0A0, 16'hC5A0, 16'hF660, 16'h86A0, 16'h87A0};
        foreach (t[i]) run(t[i]);
        for (int r = 8; r < 16; r++) begin
            run({4'hC, 4'(r), 8'h50});
            run({4'h7, 4'(r), 8'hA0});
            run({4'hA, 4'(r), 8'hA0});
        end
        run(16'hF760);
        run(16'h85F0, 1'b1);
    endtask : transfers

    initial begin
        repeat (5000) @(posedge core_clk_i);
        err_count++;
        $display("Watchdog expired before the tests ended");
        end_of_test();
    end

    initial begin
        rst_n_i = 1'b0;
        code_valid_i = 1'b0;
        pc = 16'h0000;
        err_count = 0;
        comparisons = 0;
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        code_valid_i <= 1'b1;
        #1;
        arith_ops();
        logic_ops();
        single_ops();
        transfers();
        end_of_test();
    end
endmodule : tb
